// file: hdl/aea_pkg.sv
// Constants, register map and field layout of the apparent energy accumulator.
package aea_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int SAMPLE_PERIOD_NS = 125000;
    localparam int SAMPLE_DIV = (SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SAMPLE_CNT_W = 11;

    // ------------------------------------------------------------------
    // Data widths and scaling
    // ------------------------------------------------------------------
    localparam int RMS_W = 24;
    localparam int THR_W = 48;
    localparam int ENERGY_W = 32;
    localparam int PWR_W = 28;
    localparam int ACC_W = THR_W + 1;
    localparam int PROD_W = 2 * RMS_W;
    localparam int SCALED_W = PROD_W + 26;
    localparam int POWER_SHIFT = 50;
    localparam logic [25:0] FULL_SCALE_POWER = 26'h1FF6A6B;
    localparam int NOMINAL_SCALE = 4191910;
    localparam int HALF_FULL_BIT = 30;

    // ------------------------------------------------------------------
    // Register offsets on the parallel register port
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_NOMINAL_VOLTAGE = 8'h00;
    localparam logic [7:0] OFF_VA_THRESHOLD_HIGH = 8'h01;
    localparam logic [7:0] OFF_VA_THRESHOLD_LOW = 8'h02;
    localparam logic [7:0] OFF_PHASE_A_VA_ENERGY = 8'h03;
    localparam logic [7:0] OFF_PHASE_B_VA_ENERGY = 8'h04;
    localparam logic [7:0] OFF_PHASE_C_VA_ENERGY = 8'h05;
    localparam logic [7:0] OFF_COMPENSATION_MODE = 8'h06;
    localparam logic [7:0] OFF_ACCUMULATION_MODE = 8'h07;
    localparam logic [7:0] OFF_LINE_CYCLE_MODE = 8'h08;
    localparam logic [7:0] OFF_MAIN_STATUS = 8'h09;
    localparam logic [7:0] OFF_MAIN_INTERRUPT_MASK = 8'h0A;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int COMP_MODE_W = 14;
    localparam int NOMINAL_EN_LSB = 11;
    localparam int ACC_MODE_W = 8;
    localparam int WIRING_LSB = 4;
    localparam int LCYC_MODE_W = 8;
    localparam int READ_CLEARS_BIT = 6;
    localparam int STATUS_HALF_FULL_BIT = 4;
    localparam int MASK_HALF_FULL_BIT = 4;

    localparam logic [1:0] WIRING_OWN = 2'h0;
    localparam logic [1:0] WIRING_A_MINUS_C = 2'h1;
    localparam logic [1:0] WIRING_NEG_A_MINUS_C = 2'h2;
    localparam logic [1:0] WIRING_NEG_A = 2'h3;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [RMS_W-1:0] NOMINAL_RESET = 24'h000000;
    localparam logic [THR_W-1:0] THRESHOLD_RESET = 48'h0000_01FF_6A6B;
    localparam logic [COMP_MODE_W-1:0] COMP_MODE_RESET = 14'h0000;
    localparam logic [ACC_MODE_W-1:0] ACC_MODE_RESET = 8'h00;
    localparam logic [LCYC_MODE_W-1:0] LCYC_MODE_RESET = 8'h00;

endpackage : aea_pkg

// file: hdl/aea_phase_accum.sv
// Two-stage apparent energy integrator for one phase.
`timescale 1ns/100ps
module aea_phase_accum
    import aea_pkg::*;
#(
    parameter int ENERGY_BITS = ENERGY_W
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sampleStrobe,
    input wire logic signed [PWR_W-1:0] phasePower,
    input wire logic [THR_W-1:0] threshold,
    input wire logic readClear,
    output logic energyPulse,
    output logic [ENERGY_BITS-1:0] energyCount,
    output logic halfEvent
);

    logic signed [ACC_W-1:0] stage1_ff;
    logic signed [ACC_W-1:0] nxt_stage1;
    logic signed [ACC_W-1:0] sum;
    logic signed [ACC_W-1:0] thrSigned;
    logic pulse_ff;
    logic nxt_pulse;
    logic [ENERGY_BITS-1:0] count_ff;
    logic [ENERGY_BITS-1:0] nxt_count;
    logic [ENERGY_BITS-1:0] incCount;
    logic half_ff;
    logic nxt_half;

    // ------------------------------------------------------------------
    // First stage
    // ------------------------------------------------------------------
    always_comb begin
        thrSigned = $signed({1'b0, threshold});
        sum = stage1_ff + ACC_W'(phasePower);
        nxt_stage1 = stage1_ff;
        nxt_pulse = 1'b0;
        if (sampleStrobe) begin
            if (sum >= thrSigned) begin
                nxt_pulse = 1'b1;
                nxt_stage1 = sum - thrSigned;
            end else begin
                nxt_stage1 = sum;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stage1_ff <= '0;
            pulse_ff <= 1'b0;
        end else begin
            stage1_ff <= nxt_stage1;
            pulse_ff <= nxt_pulse;
        end
    end

    // ------------------------------------------------------------------
    // Second stage
    // ------------------------------------------------------------------
    always_comb begin
        incCount = count_ff + ENERGY_BITS'(1);
        nxt_count = count_ff;
        nxt_half = 1'b0;
        if (readClear) begin
            nxt_count = '0;
        end
        if (pulse_ff) begin
            nxt_count = readClear ? ENERGY_BITS'(1) : incCount;
            nxt_half = incCount[HALF_FULL_BIT] != count_ff[HALF_FULL_BIT];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            count_ff <= '0;
            half_ff <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            half_ff <= nxt_half;
        end
    end

    assign energyPulse = pulse_ff;
    assign energyCount = count_ff;
    assign halfEvent = half_ff;

endmodule : aea_phase_accum

// file: hdl/aea_top.sv
// Three-phase apparent power and apparent energy accumulation with its registers.
`timescale 1ns/100ps
// What this block does
// - Enabled phase uses nominal voltage register times its rms current for apparent power.
// - Disabled phase, the reset default, uses rms voltage times rms current.
// - Nominal voltage is 24-bit signed, read as 32 bits with upper byte zero.
// - Every 125 us each phase power adds into its first-stage accumulator.
// - Reaching the threshold emits a pulse and subtracts the threshold, keeping remainder.
// - Pulses count in a 32-bit accumulator, transferred to the register on access.
// - Threshold is 48 bits in high and low words, upper byte reads zero.
// - Full-scale instantaneous power constant is 0x1FF6A6B.
// - Energy registers are signed counters that wrap past positive maximum.
// - Half-full flag, status bit 4, sets when a pulse increment flips bit 30 of any energy.
// - With mask bit 4 set, a set half-full flag drives interrupt low.
// - Writing status with bit 4 at 1 clears the flag; zeros change nothing.
// - With line-cycle mode bit 6 set, reading an energy register zeroes it.
// - Wiring field selects phase B voltage: own, A-C, -A-C, -A.
module aea_top
    import aea_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 32
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic signed [RMS_W-1:0] voltageRmsA,
    input wire logic signed [RMS_W-1:0] voltageRmsB,
    input wire logic signed [RMS_W-1:0] voltageRmsC,
    input wire logic signed [RMS_W-1:0] currentRmsA,
    input wire logic signed [RMS_W-1:0] currentRmsB,
    input wire logic signed [RMS_W-1:0] currentRmsC,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic regWrEn,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regRdEn,
    output logic [DATA_W-1:0] regRdData,
    output logic regRdValid,
    output logic mainInterruptN,
    output logic sampleStrobe,
    output logic [2:0] energyPulse,
    output logic [COMP_MODE_W-1:0] compensationMode
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [SAMPLE_CNT_W-1:0] sampleCnt_ff;
    logic strobe_ff;
    logic [RMS_W-1:0] nominalVoltage_ff;
    logic [THR_W-1:0] vaThreshold_ff;
    logic [COMP_MODE_W-1:0] compensation_mode_ff;
    logic [ACC_MODE_W-1:0] accumulation_mode_ff;
    logic [LCYC_MODE_W-1:0] line_cycle_mode_ff;
    logic halfFull_ff;
    logic halfMask_ff;
    logic [DATA_W-1:0] rdData_ff;
    logic rdValid_ff;
    logic [DATA_W-1:0] rdMux;
    logic wrNominal;
    logic wrThrHigh;
    logic wrThrLow;
    logic wrComp;
    logic wrAcc;
    logic wrLcyc;
    logic wrStatus;
    logic wrMask;
    logic [2:0] rdEnergy;
    logic [2:0] readClear;
    logic [2:0] halfEvent;
    logic [2:0] nominalEnable;
    logic [1:0] wiringConfig;
    logic signed [RMS_W-1:0] phaseBVoltage;
    logic signed [RMS_W-1:0] voltSel [3];
    logic signed [RMS_W-1:0] currSel [3];
    logic signed [PWR_W-1:0] phasePower [3];
    logic [ENERGY_W-1:0] energyCount [3];

    // Clamps a wide signed sum into the rms width.
    function automatic logic signed [RMS_W-1:0] sat_rms(input logic signed [RMS_W+1:0] val);
        logic signed [RMS_W+1:0] maxVal;
        logic signed [RMS_W+1:0] minVal;
        maxVal = $signed({3'h0, {(RMS_W-1){1'b1}}});
        minVal = $signed({3'h7, {(RMS_W-1){1'b0}}});
        if (val > maxVal) begin
            sat_rms = maxVal[RMS_W-1:0];
        end else if (val < minVal) begin
            sat_rms = minVal[RMS_W-1:0];
        end else begin
            sat_rms = val[RMS_W-1:0];
        end
    endfunction : sat_rms

    // Scales an rms product so that inputs of 4191910 give about a sixty-fourth of full-scale power.
    function automatic logic signed [PWR_W-1:0] scale_power(
        input logic signed [RMS_W-1:0] volt,
        input logic signed [RMS_W-1:0] curr
    );
        logic signed [PROD_W-1:0] prod;
        logic signed [SCALED_W-1:0] scaled;
        prod = volt * curr;
        scaled = SCALED_W'(prod) * $signed({{(SCALED_W-26){1'b0}}, FULL_SCALE_POWER});
        scale_power = PWR_W'(scaled >>> POWER_SHIFT);
    endfunction : scale_power

    // ------------------------------------------------------------------
    // Sample strobe
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sampleCnt_ff <= '0;
            strobe_ff <= 1'b0;
        end else if (sampleCnt_ff == SAMPLE_CNT_W'(SAMPLE_DIV - 1)) begin
            sampleCnt_ff <= '0;
            strobe_ff <= 1'b1;
        end else begin
            sampleCnt_ff <= sampleCnt_ff + SAMPLE_CNT_W'(1);
            strobe_ff <= 1'b0;
        end
    end

    assign sampleStrobe = strobe_ff;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    always_comb begin
        wrNominal = regWrEn && (regAddr == ADDR_W'(OFF_NOMINAL_VOLTAGE));
        wrThrHigh = regWrEn && (regAddr == ADDR_W'(OFF_VA_THRESHOLD_HIGH));
        wrThrLow = regWrEn && (regAddr == ADDR_W'(OFF_VA_THRESHOLD_LOW));
        wrComp = regWrEn && (regAddr == ADDR_W'(OFF_COMPENSATION_MODE));
        wrAcc = regWrEn && (regAddr == ADDR_W'(OFF_ACCUMULATION_MODE));
        wrLcyc = regWrEn && (regAddr == ADDR_W'(OFF_LINE_CYCLE_MODE));
        wrStatus = regWrEn && (regAddr == ADDR_W'(OFF_MAIN_STATUS));
        wrMask = regWrEn && (regAddr == ADDR_W'(OFF_MAIN_INTERRUPT_MASK));
        rdEnergy[0] = regRdEn && (regAddr == ADDR_W'(OFF_PHASE_A_VA_ENERGY));
        rdEnergy[1] = regRdEn && (regAddr == ADDR_W'(OFF_PHASE_B_VA_ENERGY));
        rdEnergy[2] = regRdEn && (regAddr == ADDR_W'(OFF_PHASE_C_VA_ENERGY));
        readClear = rdEnergy & {3{line_cycle_mode_ff[READ_CLEARS_BIT]}};
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            nominalVoltage_ff <= NOMINAL_RESET;
        end else if (wrNominal) begin
            nominalVoltage_ff <= regWrData[RMS_W-1:0];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            vaThreshold_ff <= THRESHOLD_RESET;
        end else begin
            if (wrThrHigh) begin
                vaThreshold_ff[THR_W-1:THR_W/2] <= regWrData[THR_W/2-1:0];
            end
            if (wrThrLow) begin
                vaThreshold_ff[THR_W/2-1:0] <= regWrData[THR_W/2-1:0];
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            compensation_mode_ff <= COMP_MODE_RESET;
        end else if (wrComp) begin
            compensation_mode_ff <= regWrData[COMP_MODE_W-1:0];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            accumulation_mode_ff <= ACC_MODE_RESET;
        end else if (wrAcc) begin
            accumulation_mode_ff <= regWrData[ACC_MODE_W-1:0];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            line_cycle_mode_ff <= LCYC_MODE_RESET;
        end else if (wrLcyc) begin
            line_cycle_mode_ff <= regWrData[LCYC_MODE_W-1:0];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            halfMask_ff <= 1'b0;
        end else if (wrMask) begin
            halfMask_ff <= regWrData[MASK_HALF_FULL_BIT];
        end
    end

    assign compensationMode = compensation_mode_ff;

    // ------------------------------------------------------------------
    // Status flag and interrupt
    // ------------------------------------------------------------------
    // A half-full event in the same cycle as the clearing write keeps the flag set.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            halfFull_ff <= 1'b0;
        end else if (|halfEvent) begin
            halfFull_ff <= 1'b1;
        end else if (wrStatus && regWrData[STATUS_HALF_FULL_BIT]) begin
            halfFull_ff <= 1'b0;
        end
    end

    assign mainInterruptN = ~(halfFull_ff & halfMask_ff);

    // ------------------------------------------------------------------
    // Power sources per phase
    // ------------------------------------------------------------------
    always_comb begin
        nominalEnable = compensation_mode_ff[NOMINAL_EN_LSB+2:NOMINAL_EN_LSB];
        wiringConfig = accumulation_mode_ff[WIRING_LSB+1:WIRING_LSB];
        case (wiringConfig)
            WIRING_OWN: begin
                phaseBVoltage = voltageRmsB;
            end
            WIRING_A_MINUS_C: begin
                phaseBVoltage = sat_rms((RMS_W+2)'(voltageRmsA) - (RMS_W+2)'(voltageRmsC));
            end
            WIRING_NEG_A_MINUS_C: begin
                phaseBVoltage = sat_rms(-(RMS_W+2)'(voltageRmsA) - (RMS_W+2)'(voltageRmsC));
            end
            WIRING_NEG_A: begin
                phaseBVoltage = sat_rms(-(RMS_W+2)'(voltageRmsA));
            end
            default: begin
                phaseBVoltage = voltageRmsB;
            end
        endcase
        voltSel[0] = voltageRmsA;
        voltSel[1] = phaseBVoltage;
        voltSel[2] = voltageRmsC;
        currSel[0] = currentRmsA;
        currSel[1] = currentRmsB;
        currSel[2] = currentRmsC;
        for (int p = 0; p < 3; p++) begin
            if (nominalEnable[p]) begin
                voltSel[p] = $signed(nominalVoltage_ff);
            end
        end
    end

    // ------------------------------------------------------------------
    // Per-phase integrators
    // ------------------------------------------------------------------
    for (genvar g = 0; g < 3; g++) begin : gen_phase
        assign phasePower[g] = scale_power(voltSel[g], currSel[g]);

        aea_phase_accum #(
            .ENERGY_BITS(ENERGY_W)
        ) u_accum (
            .sys_clk(sys_clk),
            .rst(rst),
            .sampleStrobe(strobe_ff),
            .phasePower(phasePower[g]),
            .threshold(vaThreshold_ff),
            .readClear(readClear[g]),
            .energyPulse(energyPulse[g]),
            .energyCount(energyCount[g]),
            .halfEvent(halfEvent[g])
        );
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_comb begin
        rdMux = '0;
        case (regAddr)
            ADDR_W'(OFF_NOMINAL_VOLTAGE): begin
                rdMux = DATA_W'(nominalVoltage_ff);
            end
            ADDR_W'(OFF_VA_THRESHOLD_HIGH): begin
                rdMux = DATA_W'(vaThreshold_ff[THR_W-1:THR_W/2]);
            end
            ADDR_W'(OFF_VA_THRESHOLD_LOW): begin
                rdMux = DATA_W'(vaThreshold_ff[THR_W/2-1:0]);
            end
            ADDR_W'(OFF_PHASE_A_VA_ENERGY): begin
                rdMux = DATA_W'(energyCount[0]);
            end
            ADDR_W'(OFF_PHASE_B_VA_ENERGY): begin
                rdMux = DATA_W'(energyCount[1]);
            end
            ADDR_W'(OFF_PHASE_C_VA_ENERGY): begin
                rdMux = DATA_W'(energyCount[2]);
            end
            ADDR_W'(OFF_COMPENSATION_MODE): begin
                rdMux = DATA_W'(compensation_mode_ff);
            end
            ADDR_W'(OFF_ACCUMULATION_MODE): begin
                rdMux = DATA_W'(accumulation_mode_ff);
            end
            ADDR_W'(OFF_LINE_CYCLE_MODE): begin
                rdMux = DATA_W'(line_cycle_mode_ff);
            end
            ADDR_W'(OFF_MAIN_STATUS): begin
                rdMux[STATUS_HALF_FULL_BIT] = halfFull_ff;
            end
            ADDR_W'(OFF_MAIN_INTERRUPT_MASK): begin
                rdMux[MASK_HALF_FULL_BIT] = halfMask_ff;
            end
            default: begin
                rdMux = '0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdData_ff <= '0;
            rdValid_ff <= 1'b0;
        end else begin
            rdValid_ff <= regRdEn;
            if (regRdEn) begin
                rdData_ff <= rdMux;
            end
        end
    end

    assign regRdData = rdData_ff;
    assign regRdValid = rdValid_ff;

endmodule : aea_top

// file: bench/aea_top_chk.sv
// Concurrent checks on the ports of the apparent energy accumulator.
`timescale 1ns/100ps
module aea_top_chk
    import aea_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 32
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic regWrEn,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regRdEn,
    input wire logic [DATA_W-1:0] regRdData,
    input wire logic regRdValid,
    input wire logic mainInterruptN,
    input wire logic sampleStrobe,
    input wire logic [2:0] energyPulse,
    input wire logic [COMP_MODE_W-1:0] compensationMode
);
    logic [11:0] gapCnt_ff;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            gapCnt_ff <= 12'h000;
        end else begin
            gapCnt_ff <= sampleStrobe ? 12'h000 : gapCnt_ff + 12'h001;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_read_answer: assert property (regRdEn |=> regRdValid)
        else $error("read not answered");
    a_no_stray_valid: assert property (!regRdEn |=> !regRdValid)
        else $error("read valid without a read");
    a_strobe_single: assert property (sampleStrobe |=> !sampleStrobe)
        else $error("sample strobe too long");
    a_strobe_due: assert property (gapCnt_ff <= 12'h4E2)
        else $error("sample strobe overdue");
    a_strobe_early: assert property (sampleStrobe |-> gapCnt_ff >= 12'h4E1)
        else $error("sample strobe too early");
    a_pulse_after: assert property (|energyPulse |-> $past(sampleStrobe))
        else $error("energy pulse without strobe");
    a_pad_zero: assert property (regRdEn && regAddr <= OFF_VA_THRESHOLD_LOW
        |=> regRdData[31:24] == 8'h00)
        else $error("padding byte not zero");
    a_unmapped_zero: assert property (regRdEn && regAddr > OFF_MAIN_INTERRUPT_MASK
        |=> regRdData == '0)
        else $error("unmapped read not zero");
    a_comp_write: assert property (regWrEn && regAddr == OFF_COMPENSATION_MODE
        |=> compensationMode == $past(regWrData[COMP_MODE_W-1:0]))
        else $error("compensation mode not written");
    a_clear_irq: assert property (regWrEn && regAddr == OFF_MAIN_STATUS && regWrData[4]
        && !$past(|energyPulse) |=> mainInterruptN)
        else $error("interrupt not released by clear");
    a_mask_off: assert property (regWrEn && regAddr == OFF_MAIN_INTERRUPT_MASK
        && !regWrData[4] |=> mainInterruptN)
        else $error("masked interrupt still low");
    a_irq_cause: assert property ($fell(mainInterruptN) |-> $past(|energyPulse, 2)
        || $past(regWrEn && regAddr == OFF_MAIN_INTERRUPT_MASK))
        else $error("interrupt fell without cause");
endmodule : aea_top_chk
bind aea_top aea_top_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) aea_top_chk_inst (
    .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .regRdValid(regRdValid), .mainInterruptN(mainInterruptN),
    .sampleStrobe(sampleStrobe), .energyPulse(energyPulse),
    .compensationMode(compensationMode)
);

// file: bench/aea_host_model.sv
// Host controller model that drives the register port of the accumulator.
`timescale 1ns/100ps
module aea_host_model
    import aea_pkg::*;
(
    input wire logic sys_clk,
    output logic [7:0] regAddr,
    output logic regWrEn,
    output logic [31:0] regWrData,
    output logic regRdEn
);
    initial begin
        regAddr = 8'hFF;
        regWrEn = 1'b0;
        regWrData = 32'h0;
        regRdEn = 1'b0;
    end
    // Idle address and data show the inverse of the last value.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge sys_clk);
        regWrEn <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge sys_clk);
        regRdEn <= 1'b0;
        regAddr <= ~a;
    endtask : rd
    // Nominal code for a nominal voltage equal to full scale.
    task automatic set_nominal();
        wr(OFF_NOMINAL_VOLTAGE, 32'(NOMINAL_SCALE));
    endtask : set_nominal
    // One steady sample of power is worth one energy count.
    task automatic set_threshold(input logic [47:0] t);
        wr(OFF_VA_THRESHOLD_HIGH, {8'h00, t[47:24]});
        wr(OFF_VA_THRESHOLD_LOW, {8'h00, t[23:0]});
    endtask : set_threshold
    // Bits 1, 4 and 7 of the compensation mode are always written as zero.
    task automatic set_comp(input logic [13:0] m);
        wr(OFF_COMPENSATION_MODE, {18'h0, m & 14'h3F6D});
    endtask : set_comp
endmodule : aea_host_model

// file: bench/test_apparent_energy_accumulator.sv
// Self-checking bench for the apparent energy accumulator.
`timescale 1ns/100ps
module test_apparent_energy_accumulator
    import aea_pkg::*;
;
    localparam logic [79:0] PROD = 80'(NOMINAL_SCALE) * 80'h400000 * 80'(FULL_SCALE_POWER);
    localparam logic [47:0] PWR = 48'(PROD >> 50);
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic signed [RMS_W-1:0] voltageRmsA = 24'(NOMINAL_SCALE);
    logic signed [RMS_W-1:0] voltageRmsB = 24'(NOMINAL_SCALE);
    logic signed [RMS_W-1:0] voltageRmsC = 24'(NOMINAL_SCALE);
    logic signed [RMS_W-1:0] currentRms = 24'h400000;
    logic [7:0] regAddr;
    logic regWrEn, regRdEn, regRdValid, mainInterruptN, sampleStrobe;
    logic [31:0] regWrData, regRdData;
    logic [2:0] energyPulse;
    logic [COMP_MODE_W-1:0] compensationMode;
    logic [31:0] expQ[$];
    logic [31:0] seed = 32'h05C950B2;
    int nFail = 0;
    int nCompared = 0;
    int cycles = 0;
    always #50 sys_clk = ~sys_clk;
    aea_host_model aea_host_model_inst (.sys_clk(sys_clk), .regAddr(regAddr),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn));
    aea_top aea_top_inst (.sys_clk(sys_clk), .rst(rst), .voltageRmsA(voltageRmsA),
        .voltageRmsB(voltageRmsB), .voltageRmsC(voltageRmsC), .currentRmsA(currentRms),
        .currentRmsB(currentRms), .currentRmsC(currentRms), .regAddr(regAddr),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
        .regRdData(regRdData), .regRdValid(regRdValid), .mainInterruptN(mainInterruptN),
        .sampleStrobe(sampleStrobe), .energyPulse(energyPulse),
        .compensationMode(compensationMode));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            nFail++;
        end
    endtask : cmp
    task automatic rd_exp(input logic [7:0] a, input logic [31:0] e);
        expQ.push_back(e);
        aea_host_model_inst.rd(a);
    endtask : rd_exp
    task automatic wait_strobe();
        int n;
        n = 0;
        @(negedge sys_clk);
        while (sampleStrobe !== 1'b1 && n < 1300) begin
            @(negedge sys_clk);
            n++;
        end
        nFail += int'(n >= 1300);
        repeat (5) @(posedge sys_clk);
    endtask : wait_strobe
    task automatic final_report();
        if (nFail == 0 && nCompared > 0 && expQ.size() == 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report
    // Read results are matched against the oldest expectation.
    always @(negedge sys_clk) begin
        if (regRdValid === 1'b1 && expQ.size() == 0) begin
            cmp({31'h0, regRdValid}, 32'h0);
        end else if (regRdValid === 1'b1) begin
            cmp(regRdData, expQ.pop_front());
        end
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            nFail++;
            final_report();
        end
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        rd_exp(OFF_VA_THRESHOLD_HIGH, 32'h00000001);
        rd_exp(OFF_VA_THRESHOLD_LOW, 32'h00FF6A6B);
        rd_exp(OFF_COMPENSATION_MODE, 32'h0);
        aea_host_model_inst.wr(OFF_PHASE_A_VA_ENERGY, 32'hFFFFFFFF);
        rd_exp(OFF_PHASE_A_VA_ENERGY, 32'h0);
        rd_exp(8'h0B, 32'h0);
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            aea_host_model_inst.wr(OFF_NOMINAL_VOLTAGE, seed);
            rd_exp(OFF_NOMINAL_VOLTAGE, {8'h00, seed[23:0]});
            aea_host_model_inst.set_comp(seed[13:0]);
            rd_exp(OFF_COMPENSATION_MODE, {18'h0, seed[13:0] & 14'h3F6D});
        end
        aea_host_model_inst.set_comp(14'h0);
        aea_host_model_inst.set_threshold(PWR);
        rd_exp(OFF_VA_THRESHOLD_LOW, {8'h00, PWR[23:0]});
        aea_host_model_inst.wr(OFF_LINE_CYCLE_MODE, 32'h40);
        aea_host_model_inst.wr(OFF_ACCUMULATION_MODE, 32'h10);
        aea_host_model_inst.wr(OFF_MAIN_INTERRUPT_MASK, 32'h10);
        aea_host_model_inst.wr(OFF_MAIN_STATUS, 32'h10);
        @(negedge sys_clk);
        cmp({31'h0, mainInterruptN}, 32'h1);
        aea_host_model_inst.wr(OFF_MAIN_INTERRUPT_MASK, 32'h0);
        repeat (3) wait_strobe();
        rd_exp(OFF_PHASE_A_VA_ENERGY, 32'h3);
        rd_exp(OFF_PHASE_B_VA_ENERGY, 32'h0);
        rd_exp(OFF_PHASE_C_VA_ENERGY, 32'h3);
        rd_exp(OFF_PHASE_A_VA_ENERGY, 32'h0);
        for (int w = 0; w < 4; w++) begin
            aea_host_model_inst.wr(OFF_ACCUMULATION_MODE, 32'(w << 4));
            wait_strobe();
            rd_exp(OFF_PHASE_B_VA_ENERGY, (w == 0) ? 32'h1 : 32'h0);
        end
        rd_exp(OFF_PHASE_A_VA_ENERGY, 32'h4);
        aea_host_model_inst.set_nominal();
        @(posedge sys_clk);
        voltageRmsA <= '0;
        aea_host_model_inst.set_comp(14'h0800);
        wait_strobe();
        rd_exp(OFF_PHASE_A_VA_ENERGY, 32'h1);
        aea_host_model_inst.set_comp(14'h0);
        wait_strobe();
        rd_exp(OFF_PHASE_A_VA_ENERGY, 32'h0);
        repeat (4) @(posedge sys_clk);
        final_report();
    end
endmodule : test_apparent_energy_accumulator
